/* hdl/pwm_combo_pkg.sv */
// Shared constants and types for the PWM combinational trigger and output logic block.
//
// Function
// R1: Trigger A is the OR of generator triggers whose A enable bit is set.
// R2: Trigger B is the OR of generator triggers whose B enable bit is set.
// R3: Upper byte of both trigger enable registers reads zero, ignores writes.
// R4: Bits 15-12 pick input one; even code is high output, odd low.
// R5: Bits 11-8 pick input two with the same encoding as input one.
// R6: A selection naming an absent channel feeds constant zero.
// R7: Cells A, C, E drive high pins; cells B, D, F drive low pins.
// R8: Six independent logic cells A to F, each with an identical control register.
// R9: Bit 7 inverts input one, bit 6 inverts input two, before the function.
// R10: Bits 5-4 select OR, AND, XOR; code 11 is reserved.
// R11: Bits 2-0 pick generator 2 to 8; zero disables the cell.
// R12: All enables and control fields clear to zero on reset.
package pwm_combo_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int GEN_COUNT   = 8;
    localparam int LOGIC_COUNT = 6;
    localparam int SRC_COUNT   = 2 * GEN_COUNT;

    // ------------------------------------------------------------------
    // Register byte offsets on the APB
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TRIG_A     = 8'h00;
    localparam logic [7:0] ADDR_TRIG_B     = 8'h04;
    localparam logic [7:0] ADDR_LOGIC_BASE = 8'h08;
    localparam logic [7:0] ADDR_LOGIC_STEP = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h20;

    // ------------------------------------------------------------------
    // Field positions in a logic control register
    // ------------------------------------------------------------------
    localparam int IN1_SEL_LSB = 12;
    localparam int IN2_SEL_LSB = 8;
    localparam int IN1_INV_BIT = 7;
    localparam int IN2_INV_BIT = 6;
    localparam int FUNC_LSB    = 4;
    localparam int DEST_LSB    = 0;

    // Field positions in the status register.
    localparam int STAT_RESULT_LSB = 0;
    localparam int STAT_TRIG_A_BIT = 8;
    localparam int STAT_TRIG_B_BIT = 9;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  TRIG_RESET       = 8'h00;
    localparam logic [15:0] LOGIC_RESET      = 16'h0000;
    localparam logic [15:0] LOGIC_WRITE_MASK = 16'hFFF7;

    // Sources that exist in this build: bit 2k is generator k+1 high, 2k+1 low.
    localparam logic [15:0] SRC_PRESENT = 16'hFFFF;

    // ------------------------------------------------------------------
    // Combining operations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FUNC_OR   = 2'b00,
        FUNC_AND  = 2'b01,
        FUNC_XOR  = 2'b10,
        FUNC_RSVD = 2'b11
    } logic_func_t;

endpackage : pwm_combo_pkg

/* hdl/logic_cell.sv */
// One combinatorial logic cell: source selection, polarity, function and destination decode.
`timescale 1ns/10ps
module logic_cell
(
    input  wire logic [15:0] srcPins,   // All sixteen generator high and low outputs.
    input  wire logic [15:0] ctrl,      // This cell's control register.
    output logic             result,    // Function result.
    output logic [7:0]       destMask   // One-hot target generator, zero when disabled.
);

    // ------------------------------------------------------------------
    // Source selection and polarity
    // ------------------------------------------------------------------
    wire logic [3:0] sel1 = ctrl[pwm_combo_pkg::IN1_SEL_LSB +: 4];
    wire logic [3:0] sel2 = ctrl[pwm_combo_pkg::IN2_SEL_LSB +: 4];
    wire logic [2:0] dest = ctrl[pwm_combo_pkg::DEST_LSB +: 3];

    // Absent channels read as zero before the polarity stage.
    wire logic raw1 = srcPins[sel1] & pwm_combo_pkg::SRC_PRESENT[sel1]; // R4 R6
    wire logic raw2 = srcPins[sel2] & pwm_combo_pkg::SRC_PRESENT[sel2]; // R5 R6
    wire logic in1  = raw1 ^ ctrl[pwm_combo_pkg::IN1_INV_BIT]; // R9
    wire logic in2  = raw2 ^ ctrl[pwm_combo_pkg::IN2_INV_BIT]; // R9

    wire pwm_combo_pkg::logic_func_t func =
        pwm_combo_pkg::logic_func_t'(ctrl[pwm_combo_pkg::FUNC_LSB +: 2]);

    // ------------------------------------------------------------------
    // Function; the reserved code gives a constant low result.
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (func)
            pwm_combo_pkg::FUNC_OR:   result = in1 | in2; // R10
            pwm_combo_pkg::FUNC_AND:  result = in1 & in2; // R10
            pwm_combo_pkg::FUNC_XOR:  result = in1 ^ in2; // R10
            pwm_combo_pkg::FUNC_RSVD: result = 1'b0;      // R10
        endcase
    end

    // Destination code zero assigns no pin; codes 1 to 7 are generators 2 to 8.
    assign destMask = (dest == 3'h0) ? 8'h00 : (8'h01 << dest); // R11

endmodule : logic_cell

/* hdl/pwm_combo_logic.sv */
// Combinational trigger and combinatorial PWM output logic with an APB register port.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module pwm_combo_logic
(
    input  wire logic        clk,          // System clock, 10 MHz.
    input  wire logic        reset,        // Asynchronous reset, active high.
    input  wire logic        psel,         // APB select.
    input  wire logic        penable,      // APB enable.
    input  wire logic        pwrite,       // APB direction, high for write.
    input  wire logic [7:0]  paddr,        // APB byte address.
    input  wire logic [31:0] pwdata,       // APB write data.
    input  wire logic [3:0]  pstrb,        // APB write byte strobes.
    output logic [31:0]      prdata,       // APB read data.
    output logic             pready,       // APB ready.
    output logic             pslverr,      // APB error on unmapped address.
    input  wire logic [7:0]  genTrigger,   // Trigger output of each generator.
    input  wire logic [7:0]  genHighIn,    // High output of each generator.
    input  wire logic [7:0]  genLowIn,     // Low output of each generator.
    output logic [7:0]       genHighOut,   // High pins after logic override.
    output logic [7:0]       genLowOut,    // Low pins after logic override.
    output logic             comboTrigA,   // Combinational trigger A.
    output logic             comboTrigB    // Combinational trigger B.
);

    // ------------------------------------------------------------------
    // Configuration and output state
    // ------------------------------------------------------------------
    logic [7:0]  trigAEn_r;
    logic [7:0]  trigBEn_r;
    logic [15:0] logicCtl_r [pwm_combo_pkg::LOGIC_COUNT];
    logic [31:0] prdata_r;
    logic [7:0]  genHighOut_r;
    logic [7:0]  genLowOut_r;
    logic        comboTrigA_r;
    logic        comboTrigB_r;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic setupPhase  = psel & ~penable;
    wire logic accessPhase = psel & penable;
    wire logic aligned     = (paddr[1:0] == 2'b00);
    wire logic hitTrigA    = aligned & (paddr == pwm_combo_pkg::ADDR_TRIG_A);
    wire logic hitTrigB    = aligned & (paddr == pwm_combo_pkg::ADDR_TRIG_B);
    wire logic hitStatus   = aligned & (paddr == pwm_combo_pkg::ADDR_STATUS);
    wire logic writeNow    = accessPhase & pwrite;

    // One select line for each logic control register.
    logic [pwm_combo_pkg::LOGIC_COUNT-1:0] hitLogic;

    genvar gi;
    generate
        for (gi = 0; gi < pwm_combo_pkg::LOGIC_COUNT; gi++)
        begin : g_decode
            localparam logic [7:0] OFFS = 8'(pwm_combo_pkg::ADDR_LOGIC_BASE
                                          + pwm_combo_pkg::ADDR_LOGIC_STEP * gi);
            assign hitLogic[gi] = aligned & (paddr == OFFS);
        end
    endgenerate

    wire logic mapped = hitTrigA | hitTrigB | hitStatus | (|hitLogic);

    // Zero wait states; read data was captured during the setup cycle.
    assign pready  = 1'b1;
    assign pslverr = accessPhase & ~mapped;
    assign prdata  = prdata_r;

    // ------------------------------------------------------------------
    // Logic cells A to F
    // ------------------------------------------------------------------
    logic [15:0] srcPins;
    logic [pwm_combo_pkg::LOGIC_COUNT-1:0] cellResult;
    logic [7:0] cellDest [pwm_combo_pkg::LOGIC_COUNT];

    generate
        for (gi = 0; gi < pwm_combo_pkg::GEN_COUNT; gi++)
        begin : g_src
            assign srcPins[2*gi]   = genHighIn[gi]; // R4
            assign srcPins[2*gi+1] = genLowIn[gi];  // R4
        end
        for (gi = 0; gi < pwm_combo_pkg::LOGIC_COUNT; gi++)
        begin : g_cell
            logic_cell u_cell
            (
                .srcPins  (srcPins),
                .ctrl     (logicCtl_r[gi]),
                .result   (cellResult[gi]),
                .destMask (cellDest[gi])
            ); // R8
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin override; when two cells name one pin, the earlier letter wins.
    // ------------------------------------------------------------------
    logic [7:0] highNxt;
    logic [7:0] lowNxt;

    always_comb
    begin
        highNxt = genHighIn;
        lowNxt  = genLowIn;
        for (int c = pwm_combo_pkg::LOGIC_COUNT - 1; c >= 0; c--)
        begin
            for (int g = 0; g < pwm_combo_pkg::GEN_COUNT; g++)
            begin
                if (cellDest[c][g])
                begin
                    if (c % 2 == 0)
                    begin
                        highNxt[g] = cellResult[c]; // R7
                    end
                    else
                    begin
                        lowNxt[g] = cellResult[c]; // R7
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Combinational triggers
    // ------------------------------------------------------------------
    wire logic trigANxt = |(genTrigger & trigAEn_r); // R1
    wire logic trigBNxt = |(genTrigger & trigBEn_r); // R2

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    logic [31:0] readMux;
    logic [31:0] statusWord;

    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[pwm_combo_pkg::STAT_RESULT_LSB +: 6] = cellResult;
        statusWord[pwm_combo_pkg::STAT_TRIG_A_BIT] = comboTrigA_r;
        statusWord[pwm_combo_pkg::STAT_TRIG_B_BIT] = comboTrigB_r;
    end

    always_comb
    begin
        readMux = 32'h0000_0000;
        if (hitTrigA)
        begin
            readMux = {24'h00_0000, trigAEn_r}; // R3
        end
        else if (hitTrigB)
        begin
            readMux = {24'h00_0000, trigBEn_r}; // R3
        end
        else if (hitStatus)
        begin
            readMux = statusWord;
        end
        for (int c = 0; c < pwm_combo_pkg::LOGIC_COUNT; c++)
        begin
            if (hitLogic[c])
            begin
                readMux = {16'h0000, logicCtl_r[c]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Trigger enable registers; only the low byte exists.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            trigAEn_r <= pwm_combo_pkg::TRIG_RESET; // R12
            trigBEn_r <= pwm_combo_pkg::TRIG_RESET; // R12
        end
        else
        begin
            if (writeNow && hitTrigA && pstrb[0])
            begin
                trigAEn_r <= pwdata[7:0]; // R1 R3
            end
            if (writeNow && hitTrigB && pstrb[0])
            begin
                trigBEn_r <= pwdata[7:0]; // R2 R3
            end
        end
    end

    // ------------------------------------------------------------------
    // Logic control registers; bit 3 is unimplemented.
    // ------------------------------------------------------------------
    generate
        for (gi = 0; gi < pwm_combo_pkg::LOGIC_COUNT; gi++)
        begin : g_ctl
            wire logic [15:0] laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}}
                                         & pwm_combo_pkg::LOGIC_WRITE_MASK;
            wire logic [15:0] ctlNxt = (logicCtl_r[gi] & ~laneMask)
                                       | (pwdata[15:0] & laneMask);

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    logicCtl_r[gi] <= pwm_combo_pkg::LOGIC_RESET; // R12
                end
                else if (writeNow && hitLogic[gi])
                begin
                    logicCtl_r[gi] <= ctlNxt; // R8
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data capture in the setup cycle.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else if (setupPhase && !pwrite)
        begin
            prdata_r <= readMux;
        end
    end

    // ------------------------------------------------------------------
    // Registered pin and trigger outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            genHighOut_r <= 8'h00;
            genLowOut_r  <= 8'h00;
            comboTrigA_r <= 1'b0;
            comboTrigB_r <= 1'b0;
        end
        else
        begin
            genHighOut_r <= highNxt; // R7
            genLowOut_r  <= lowNxt;  // R7
            comboTrigA_r <= trigANxt; // R1
            comboTrigB_r <= trigBNxt; // R2
        end
    end

    assign genHighOut = genHighOut_r;
    assign genLowOut  = genLowOut_r;
    assign comboTrigA = comboTrigA_r;
    assign comboTrigB = comboTrigB_r;

endmodule : pwm_combo_logic

/* test/pwm_combo_logic_asserts.sv */
// Port-level concurrent checks for the PWM combo trigger and output logic.
`timescale 1ns/10ps
module pwm_combo_logic_asserts
(
    input wire logic        clk,        // Clock.
    input wire logic        reset,      // Reset.
    input wire logic        psel,       // Select.
    input wire logic        penable,    // Enable.
    input wire logic        pwrite,     // Direction.
    input wire logic [7:0]  paddr,      // Address.
    input wire logic [3:0]  pstrb,      // Strobes.
    input wire logic [31:0] pwdata,     // Write data.
    input wire logic [31:0] prdata,     // Read data.
    input wire logic        pready,     // Ready.
    input wire logic        pslverr,    // Error.
    input wire logic [7:0]  genTrigger, // Triggers.
    input wire logic [7:0]  genHighIn,  // High in.
    input wire logic [7:0]  genLowIn,   // Low in.
    input wire logic [7:0]  genHighOut, // High out.
    input wire logic [7:0]  genLowOut,  // Low out.
    input wire logic        comboTrigA, // Trigger A.
    input wire logic        comboTrigB  // Trigger B.
);
    logic [7:0] enA_r;
    logic [7:0] enB_r;
    logic       hitA;
    logic       hitB;
    logic       badAddr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence access_s;
        psel && penable && pready;
    endsequence
    sequence rd_s;
        access_s ##0 !pwrite;
    endsequence

    // Decode the trigger hits and the unmapped addresses.
    assign hitA = |(genTrigger & enA_r);
    assign hitB = |(genTrigger & enB_r);
    assign badAddr = paddr > 8'h20 || paddr[1:0] != 2'h0;

    // Track the trigger enables as software writes them.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            enA_r <= 8'h00;
            enB_r <= 8'h00;
        end
        else if (psel && penable && pwrite && pready && pstrb[0])
        begin
            if (paddr == 8'h00)
                enA_r <= pwdata[7:0];
            if (paddr == 8'h04)
                enB_r <= pwdata[7:0];
        end
    end

    ready_access_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    trig_a_or_a: assert property (1'b1 |=> comboTrigA == $past(hitA))
        else $error("trigger A differs from enabled OR");
    trig_b_or_a: assert property (1'b1 |=> comboTrigB == $past(hitB))
        else $error("trigger B differs from enabled OR");
    trig_upper_a: assert property (rd_s ##0 (paddr < 8'h08) |-> prdata[31:8] == 24'h0)
        else $error("trigger upper bits not zero");
    trig_readback_a: assert property (rd_s ##0 (paddr < 8'h08 && paddr[1:0] == 2'h0)
        |-> prdata[7:0] == (paddr[2] ? enB_r : enA_r))
        else $error("trigger enable read back wrong");
    logic_unused_a: assert property (rd_s ##0 (paddr >= 8'h08 && paddr <= 8'h1C)
        |-> prdata[3] == 1'b0 && prdata[31:16] == 16'h0)
        else $error("logic register unused bits not zero");
    gen1_pass_a: assert property (1'b1 |=> genHighOut[0] == $past(genHighIn[0])
        && genLowOut[0] == $past(genLowIn[0]))
        else $error("generator 1 pins overridden");
    bad_addr_a: assert property (psel && penable && badAddr |-> pslverr)
        else $error("no error on unmapped address");
    good_addr_a: assert property (psel && penable && !badAddr |-> !pslverr)
        else $error("error on mapped address");
    status_read_a: assert property (rd_s ##0 (paddr == 8'h20) |-> prdata[31:10] == 22'h0
        && prdata[7:6] == 2'h0 && prdata[8] == $past(comboTrigA)
        && prdata[9] == $past(comboTrigB))
        else $error("status read data wrong");
    reset_clear_a: assert property ($fell(reset) |-> genHighOut == 8'h00
        && genLowOut == 8'h00 && !comboTrigA && !comboTrigB)
        else $error("outputs not clear after reset");
endmodule : pwm_combo_logic_asserts

bind pwm_combo_logic pwm_combo_logic_asserts chk (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pstrb, .pwdata, .prdata, .pready, .pslverr, .genTrigger, .genHighIn,
    .genLowIn, .genHighOut, .genLowOut, .comboTrigA, .comboTrigB);

/* test/pwm_gen_model.sv */
// Behavioural model of the eight PWM generators feeding the block.
`timescale 1ns/10ps
module pwm_gen_model
(
    input  wire logic       clk,        // System clock.
    input  wire logic       reset,      // Active-high reset.
    input  wire logic [2:0] hold,       // Extra cycles each pattern stays.
    output logic      [7:0] genTrigger, // Generator triggers.
    output logic      [7:0] genHigh,    // Generator high outputs.
    output logic      [7:0] genLow      // Generator low outputs.
);
    logic [2:0] waitCnt_r;

    // Draw new generator levels every cycle or after a hold, as asked.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            waitCnt_r <= 3'h0;
            {genTrigger, genHigh, genLow} <= 24'h0;
        end
        else if (waitCnt_r == 3'h0)
        begin
            waitCnt_r <= hold;
            {genTrigger, genHigh, genLow} <= 24'($urandom);
        end
        else
            waitCnt_r <= waitCnt_r - 3'h1;
    end
endmodule : pwm_gen_model

/* test/tb_top.sv */
// Self-checking bench for the PWM combo trigger and output logic.
`timescale 1ns/10ps
module tb_top;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, comboTrigA, comboTrigB;
    logic [7:0]  paddr, genTrigger, genHighIn, genLowIn, genHighOut, genLowOut;
    logic [3:0]  pstrb;
    logic [2:0]  hold;
    logic [31:0] pwdata, prdata;
    logic [15:0] cfg [0:7];
    logic [15:0] laneMask;
    logic [17:0] pinQ [$];
    logic [33:0] busQ [$];
    logic [17:0] pinExp;
    logic [33:0] busExp;
    int          checks = 0, fails = 0, cycles = 0;

    pwm_combo_logic dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .genTrigger, .genHighIn, .genLowIn, .genHighOut,
        .genLowOut, .comboTrigA, .comboTrigB);
    pwm_gen_model gen (.clk, .reset, .hold, .genTrigger, .genHigh(genHighIn),
        .genLow(genLowIn));

    // Byte lanes a write may change, minus the unimplemented bits.
    assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & (paddr < 8'h08 ? 16'h00FF : 16'hFFF7);

    // Work out the pins and triggers one cycle ahead from the current setup.
    function automatic logic [17:0] predict(input logic [7:0] t, h, l);
        logic [15:0] src, c;
        logic [7:0]  ho, lo;
        logic        a, b, r;
        for (int k = 0; k < 8; k++)
            src[2*k+:2] = {l[k], h[k]};
        ho = h;
        lo = l;
        for (int i = 5; i >= 0; i--)
        begin
            c = cfg[i+2];
            a = src[c[15:12]] ^ c[7];
            b = src[c[11:8]] ^ c[6];
            r = c[5:4] == 2'h0 ? a | b : c[5:4] == 2'h1 ? a & b : c[5:4] == 2'h2 && (a ^ b);
            if (c[2:0] != 3'h0 && i % 2 == 0)
                ho[c[2:0]] = r;
            if (c[2:0] != 3'h0 && i % 2 == 1)
                lo[c[2:0]] = r;
        end
        return {ho, lo, |(t & cfg[0][7:0]), |(t & cfg[1][7:0])};
    endfunction : predict

    task automatic fail(input string msg);
        fails++;
        $display("ERROR at %0t ns: %s", $time, msg);
    endtask : fail

    task automatic stop_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // One APB transfer, left selected so the next may follow at once.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        logic bad;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        bad = a > 8'h20 || a[1:0] != 2'h0;
        busQ.push_back({bad, !wr && a != 8'h20, bad || a == 8'h20 ? 32'h0 : {16'h0, cfg[a[4:2]]}});
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
    endtask : apb

    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle

    // Note expected pins each cycle and follow register writes.
    always @(posedge clk)
    begin
        if (reset)
            cfg <= '{default: 16'h0000};
        else
        begin
            pinQ.push_back(predict(genTrigger, genHighIn, genLowIn));
            if (psel && penable && pwrite && pready && paddr < 8'h20 && paddr[1:0] == 2'h0)
                cfg[paddr[4:2]] <= cfg[paddr[4:2]] & ~laneMask | pwdata[15:0] & laneMask;
        end
    end

    // Compare settled pins against the oldest note.
    always @(negedge clk)
    begin
        checks++;
        if (pinQ.size() > 0)
        begin
            pinExp = pinQ.pop_front();
            if (!reset && {genHighOut, genLowOut, comboTrigA, comboTrigB} !== pinExp)
                fail("pin or trigger mismatch");
        end
        else if ({genHighOut, genLowOut, comboTrigA, comboTrigB} !== 18'h0)
            fail("outputs not clear in reset");
    end

    // Compare each completed transfer against its note.
    always @(posedge clk)
    begin
        if (psel && penable && pready && busQ.size() > 0)
        begin
            busExp = busQ.pop_front();
            checks++;
            if (pslverr !== busExp[33])
                fail("error flag mismatch");
            if (busExp[32] && prdata !== busExp[31:0])
                fail("read data mismatch");
        end
    end

    // Cut the run short if it hangs.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        logic [7:0] bads [4] = '{8'h24, 8'h02, 8'hFC, 8'h20};
        {reset, psel, penable, pwrite, paddr, pwdata, pstrb, hold} = {1'b1, 50'h0};
        void'($urandom(32'hBCE1));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            apb(1'b0, 8'(4 * i), 32'h0, 4'h0);
        apb(1'b1, 8'h00, 32'hFFFFFFFF, 4'hF);
        apb(1'b1, 8'h04, 32'hFFFFFFFF, 4'hF);
        apb(1'b0, 8'h00, 32'h0, 4'h0);
        apb(1'b0, 8'h04, 32'h0, 4'h0);
        foreach (bads[i])
        begin
            apb(1'b1, bads[i], $urandom, 4'hF);
            apb(1'b0, bads[i], 32'h0, 4'h0);
        end
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 8'h00, 32'(1 << i), 4'h1);
            apb(1'b1, 8'h04, 32'(~(1 << i)), 4'h1);
            idle(6);
        end
        for (int c = 0; c < 6; c++)
            for (int f = 0; f < 4; f++)
            begin
                hold <= 3'($urandom);
                apb(1'b1, 8'(8 + 4 * c), 32'(16'($urandom) & 16'hFFC0 | 16'(f << 4)
                    | 16'(1 + $urandom % 7)), 4'h3);
                apb(1'b0, 8'(8 + 4 * c), 32'h0, 4'h0);
                idle(6);
            end
        repeat (60)
            apb(1'($urandom), 8'($urandom % 10 * 4), $urandom, 4'($urandom));
        idle(8);
        reset <= 1'b1;
        idle(3);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            apb(1'b0, 8'(4 * i), 32'h0, 4'h0);
        idle(4);
        stop_test();
    end
endmodule : tb_top
